// [rtl/drg_refresh_gen.sv]
// Refresh row counter, pacing timebase and address multiplexer
`timescale 1ns/100ps
`default_nettype none
module drg_refresh_gen #(
  parameter int TICK_CYCLES = drg_pkg::TICK_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_refresh_grant,
  input wire logic i_refresh_done,
  input wire logic [7:0] i_access_addr,
  output logic o_refresh_req,
  output logic o_refresh_cycle,
  output logic [7:0] o_mem_addr,
  output logic o_refresh_row_msb,
  output logic [7:0] o_refresh_row
);
  // ----------------------------------------
  // Timebase
  // ----------------------------------------
  // Width of the tick divider and its last count
  localparam int TW = $clog2(TICK_CYCLES);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  localparam logic [TW-1:0] TICK_ONE = TW'(1);
  // Whole row sweep must fit inside one refresh window
  localparam longint SWEEP_CYCLES = longint'(drg_pkg::ROWS) * longint'(TICK_CYCLES);
  localparam longint WINDOW_CYCLES = longint'(drg_pkg::CLK_HZ / 1_000_000) * longint'(drg_pkg::WINDOW_US);
  localparam bit WINDOW_OK = (SWEEP_CYCLES <= WINDOW_CYCLES);
  logic [TW-1:0] tick_cnt;
  logic in_refresh;
  // One-cycle strobe at the end of each divider period
  wire tick = (tick_cnt == TICK_LAST);
  wire [TW-1:0] next_tick_cnt = tick ? '0 : tick_cnt + TICK_ONE;
  // same per-row rate serves 16K parts
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end
  // ----------------------------------------
  // Request and cycle control
  // ----------------------------------------
  // A grant counts only while a request waits and the bus is free
  wire grant_take = o_refresh_req & i_refresh_grant & ~in_refresh;
  // Done outside a refresh cycle is ignored
  wire finish = in_refresh & i_refresh_done;
  // tick sets, grant clears; set wins
  wire next_req = tick | (o_refresh_req & ~grant_take);
  // Refresh stays open from grant until done is seen
  wire next_in_refresh = grant_take | (in_refresh & ~i_refresh_done);
  // Pending request and open cycle
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_refresh_req <= 1'b0;
      in_refresh <= 1'b0;
    end else begin
      o_refresh_req <= next_req;
      in_refresh <= next_in_refresh;
    end
  end
  // ----------------------------------------
  // Row counter
  // ----------------------------------------
  // full 8-bit counter covers 256 rows
  // step and wrap after each completed refresh
  wire [7:0] next_row = finish ? o_refresh_row + 8'h01 : o_refresh_row;
  // Row counter register
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_refresh_row <= drg_pkg::ROW_RST;
    end else begin
      o_refresh_row <= next_row;
    end
  end
  // ----------------------------------------
  // Address multiplexer
  // ----------------------------------------
  // 8-bit mux onto the 8-bit bus
  wire next_cycle = next_in_refresh;
  // Row is latched at grant and held for the whole refresh cycle
  wire [7:0] held_addr = grant_take ? o_refresh_row : o_mem_addr;
  wire [7:0] next_addr = next_cycle ? held_addr : i_access_addr;
  drg_pkg::drg_bus_s next_bus;
  assign next_bus.addr = next_addr;
  assign next_bus.refresh_row_msb = next_addr[7];
  // Bus registers, so every bus output comes from a flip-flop
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mem_addr <= drg_pkg::ADDR_RST;
      o_refresh_row_msb <= 1'b0;
      o_refresh_cycle <= 1'b0;
    end else begin
      o_mem_addr <= next_bus.addr;
      o_refresh_row_msb <= next_bus.refresh_row_msb;
      o_refresh_cycle <= next_cycle;
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // Grant opens a refresh cycle carrying the row
  sequence refresh_open_s;
    grant_take ##1 o_refresh_cycle;
  endsequence
  // Done closes the cycle and hands the bus back
  sequence refresh_close_s;
    finish ##1 !o_refresh_cycle;
  endsequence
  // granted request clears unless a tick lands
  req_clears_a: assert property (grant_take && !tick |=> !o_refresh_req)
    else $error("request kept after grant");
  // no cycle opens without a request
  no_req_idle_a: assert property (!o_refresh_req && !in_refresh |=> !o_refresh_cycle)
    else $error("refresh cycle without request");
  // grant leads into a refresh cycle
  open_seq_a: assert property (grant_take |-> refresh_open_s)
    else $error("grant did not open a cycle");
  // done ends the cycle one edge later
  close_seq_a: assert property (finish |-> refresh_close_s)
    else $error("done did not close the cycle");
  // address holds while the cycle stays open
  addr_holds_a: assert property (in_refresh && !i_refresh_done |=> o_refresh_cycle && $stable(o_mem_addr))
    else $error("address moved during refresh");
  // access address passes through when idle
  access_pass_a: assert property (!next_cycle |=> o_mem_addr == $past(i_access_addr) && !o_refresh_cycle)
    else $error("access address not passed");
  tick_range_a: assert property (tick_cnt <= TICK_LAST)
    else $error("divider out of range");
  // sweep of all rows fits the window
  window_fit_a: assert property (WINDOW_OK)
    else $error("tick period too long for window");
  // counter reaches the top row bit
  top_half_a: assert property (finish && o_refresh_row == 8'h7f |=> o_refresh_row[7])
    else $error("counter lacks eighth bit");
  tick_raises_req_a: assert property (tick |=> o_refresh_req)
    else $error("tick did not raise request");
  req_holds_a: assert property (o_refresh_req & ~i_refresh_grant |=> o_refresh_req)
    else $error("request dropped without grant");
  row_steps_a: assert property (finish |=> o_refresh_row == $past(o_refresh_row) + 8'h01)
    else $error("row did not step");
  row_holds_a: assert property (!finish |=> $stable(o_refresh_row))
    else $error("row changed without refresh");
  grant_addr_a: assert property (grant_take |=> o_mem_addr == $past(o_refresh_row) && o_refresh_cycle)
    else $error("row not on bus at refresh");
  msb_match_a: assert property (o_refresh_cycle |-> o_refresh_row_msb == o_mem_addr[7])
    else $error("row msb not presented");
  msb_always_a: assert property (grant_take && o_refresh_row[7] |=> o_refresh_row_msb)
    else $error("eighth bit lost");
  tick_period_a: assert property (tick |=> !tick[*8])
    else $error("ticks too close");
  wrap_a: assert property (finish && o_refresh_row == 8'hff |=> o_refresh_row == 8'h00)
    else $error("row did not wrap");
endmodule
`default_nettype wire

// [inc/drg_pkg.sv]
// Package with constants and types for the refresh row generator
package drg_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_HZ = 64_000;
  // Longest interval between ticks, rounded down
  localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
  localparam int ROW_W = 8;
  localparam int ROWS = 256;
  localparam int WINDOW_US = 4000;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [ROW_W-1:0] ROW_RST = 8'h00;
  localparam logic [ROW_W-1:0] ADDR_RST = 8'h00;
  // Address bus bundle
  typedef struct packed {
    logic [ROW_W-1:0] addr;
    logic refresh_row_msb;
  } drg_bus_s;
endpackage

// [bench/drg_mem_model.sv]
// Arbiter and memory model that grants refresh and ends each cycle
`timescale 1ns/100ps
`default_nettype none
module drg_mem_model (
  input wire logic i_core_clk,
  input wire logic i_req,
  input wire logic i_cycle,
  input wire logic [3:0] i_wait,
  output logic o_grant,
  output logic o_done
);
  logic [3:0] cnt = 4'h0;
  // Grant a pending request, end refresh after i_wait+1 cycles
  always @(posedge i_core_clk) begin
    #1;
    o_grant = i_req && !i_cycle;
    cnt = i_cycle ? cnt + 4'h1 : 4'h0;
    o_done = i_cycle && (cnt > i_wait);
  end
endmodule
`default_nettype wire

// [bench/drg_refresh_gen_tb_top.sv]
// Bench for the refresh row generator
`timescale 1ns/100ps
`default_nettype none
module drg_refresh_gen_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] acc = 8'h5a;
  logic [3:0] wt = 4'h0;
  logic gnt, done, req, cyc, msb;
  logic [7:0] addr, row;
  int n_errors = 0;
  int total_checks = 0;
  always #5 clk = ~clk;
  drg_refresh_gen #(.TICK_CYCLES(16)) u_drg_refresh_gen (.i_core_clk(clk), .i_rst(rst), .i_refresh_grant(gnt),
    .i_refresh_done(done), .i_access_addr(acc), .o_refresh_req(req), .o_refresh_cycle(cyc), .o_mem_addr(addr),
    .o_refresh_row_msb(msb), .o_refresh_row(row));
  drg_mem_model u_drg_mem_model (.i_core_clk(clk), .i_req(req), .i_cycle(cyc), .i_wait(wt), .o_grant(gnt),
    .o_done(done));
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Rows in order with top bit, wrap, pacing and access pass-through
  task automatic t_walk(input int n);
    logic [7:0] exp;
    int k;
    exp = 8'h00;
    for (int i = 0; i < n; i++) begin
      if (i == 258) wt = 4'h9;
      acc = ~exp;
      for (k = 0; k < 40 && cyc !== 1'b1; k++) begin
        @(posedge clk);
        #1;
      end
      check(9'(k <= 17), 9'h1);
      check({msb, addr}, {exp[7], exp});
      for (k = 0; k < 40 && cyc !== 1'b0; k++) begin
        @(posedge clk);
        #1;
      end
      exp++;
      check({1'b0, row}, {1'b0, exp});
      check({msb, addr}, {acc[7], acc});
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1;
    check({req, addr}, 9'h0);
    check({cyc, row}, 9'h0);
    rst = 1'b0;
    t_walk(261);
    complete_run();
  end
  initial begin
    #200000;
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
